/* File: logic/aps_alert2_route.sv */
// second alert pin source routing with its AXI4-Lite register slave
// assumes inputs synchronous to clk_i; alert sources are active-high levels
//
// Decided for this implementation: the register offsets and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
module aps_alert2_route import aps_pkg::*; #(
    parameter int FILL_W = 16
) (
    // clock, reset, enable
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    // axi4-lite write
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // axi4-lite read
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // alert sources, index 0 is channel 1
    input wire logic [3:0] uv_alert_i,
    input wire logic [3:0] op_alert_i,
    input wire logic [4*FILL_W-1:0] accum_fill_i,
    input wire logic [3:0] accum_ovf_i,
    input wire logic [FILL_W-1:0] count_fill_i,
    input wire logic count_ovf_i,
    input wire logic conv_done_i,
    // second alert pin, open drain
    input wire logic second_alert_pin_i,
    output logic second_alert_pin_o,
    output logic second_alert_pin_oe_n_o,
    output logic slow_request_o
);
    logic [MASK_W-1:0] mask_q;
    logic [15:0] full_q;
    logic [0:0] ctrl_q;
    logic aw_hold_q;
    logic [7:0] awaddr_q;
    logic w_hold_q;
    logic [31:0] wdata_q;
    logic [3:0] wstrb_q;
    logic bvalid_q;
    logic [1:0] bresp_q;
    logic rvalid_q;
    logic [31:0] rdata_q;
    logic [1:0] rresp_q;
    logic rd_mask_q;
    logic [PULSE_CNT_W-1:0] pulse_cnt_q;
    logic alert_q;
    logic oe_n_q;
    logic slow_q;

    wire logic alert_mode;
    wire logic [4:0] trip;
    wire logic [3:0] uv_en;
    wire logic [3:0] op_en;
    wire logic [5*FILL_W-1:0] all_fill;
    wire logic [4:0] all_ovf;
    wire logic pulse_en;
    wire logic pulse_on;
    wire logic alert_d;

    assign alert_mode = ctrl_q[ALERT_MODE_BIT];
    assign all_fill = {count_fill_i, accum_fill_i};
    assign all_ovf = {count_ovf_i, accum_ovf_i};

    // per-source enables and fullness comparators; counter is slot 4
    for (genvar i = 0; i < 5; i++)
    begin : g_src
        aps_fill_if #(.FILL_W(FILL_W)) fif ();
        assign fif.level = all_fill[i*FILL_W +: FILL_W];
        assign fif.ovf = all_ovf[i];
        assign fif.code = full_q[FULL_CH1_LSB - 2*i +: 2]; // R10
        assign trip[i] = fif.trip;
        aps_fill_chk #(.FILL_W(FILL_W)) u_chk (
            .clk_i(clk_i),
            .rst_i(rst_i),
            .ce_i(ce_i),
            .fill(fif)
        );
        if (i < 4)
        begin : g_ch
            assign uv_en[i] = mask_q[UV_CH1_BIT - i]; // R1
            assign op_en[i] = mask_q[OP_CH1_BIT - i]; // R2
        end
    end

    // pin source merge
    assign pulse_en = mask_q[PULSE_BIT];
    assign pulse_on = pulse_cnt_q != '0;
    assign alert_d = (|(uv_alert_i & uv_en)) // R1
                   | (|(op_alert_i & op_en)) // R2
                   | (mask_q[ACC_BIT] & (|trip[3:0])) // R3
                   | (mask_q[CNT_BIT] & trip[4]) // R4
                   | pulse_on; // R11

    // conversion-end pulse, restarted by each new conversion end
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            pulse_cnt_q <= '0;
        else if (ce_i)
        begin
            if (!pulse_en)
                pulse_cnt_q <= '0; // R5
            else if (conv_done_i)
                pulse_cnt_q <= PULSE_CNT_W'(PULSE_CYC); // R5
            else if (pulse_on)
                pulse_cnt_q <= pulse_cnt_q - 1'b1;
        end
    end

    // pin drive only in alert function; slow input only otherwise
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            alert_q <= 1'b0;
            oe_n_q <= 1'b1;
            slow_q <= 1'b0;
        end
        else if (ce_i)
        begin
            alert_q <= alert_d; // R11
            oe_n_q <= ~(alert_mode & alert_d); // R6
            slow_q <= ~alert_mode & second_alert_pin_i; // R7
        end
    end

    assign second_alert_pin_o = 1'b0; // open drain: pulls low when enabled
    assign second_alert_pin_oe_n_o = oe_n_q;
    assign slow_request_o = slow_q;

    // bus handshakes; ce low refuses every channel
    wire logic aw_take;
    wire logic w_take;
    wire logic ar_take;
    wire logic do_write;
    wire logic [31:0] byte_mask;
    wire logic [31:0] mask_merge;
    wire logic [31:0] full_merge;
    wire logic [31:0] ctrl_merge;
    wire logic wr_hit;
    wire logic rd_hit;
    wire logic [31:0] rd_word;

    assign s_axi_awready = ce_i & ~aw_hold_q & ~bvalid_q;
    assign s_axi_wready = ce_i & ~w_hold_q & ~bvalid_q;
    assign s_axi_arready = ce_i & ~rvalid_q;
    assign aw_take = s_axi_awvalid & s_axi_awready;
    assign w_take = s_axi_wvalid & s_axi_wready;
    assign ar_take = s_axi_arvalid & s_axi_arready;
    assign do_write = aw_hold_q & w_hold_q & ~bvalid_q;
    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp = bresp_q;
    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rdata = rdata_q;
    assign s_axi_rresp = rresp_q;

    // byte-lane merge of write data into each register
    assign byte_mask = {{8{wstrb_q[3]}}, {8{wstrb_q[2]}}, {8{wstrb_q[1]}}, {8{wstrb_q[0]}}};
    assign mask_merge = ({8'h00, mask_q} & ~byte_mask) | (wdata_q & byte_mask);
    assign full_merge = ({16'h0000, full_q} & ~byte_mask) | (wdata_q & byte_mask);
    assign ctrl_merge = ({31'h00000000, ctrl_q} & ~byte_mask) | (wdata_q & byte_mask);
    assign wr_hit = (awaddr_q == MASK_ADDR) | (awaddr_q == FULL_ADDR) | (awaddr_q == CTRL_ADDR);

    // read decode; bits above each register, mask bit 0 and fullness bits 5:0 read zero
    assign rd_hit = (s_axi_araddr == MASK_ADDR) | (s_axi_araddr == FULL_ADDR)
                  | (s_axi_araddr == CTRL_ADDR) | (s_axi_araddr == STAT_ADDR);
    assign rd_word = (s_axi_araddr == MASK_ADDR) ? {8'h00, mask_q & MASK_WMASK} : // R8
                     (s_axi_araddr == FULL_ADDR) ? {16'h0000, full_q & FULL_WMASK} :
                     (s_axi_araddr == CTRL_ADDR) ? {31'h00000000, ctrl_q} :
                     (s_axi_araddr == STAT_ADDR) ? {24'h000000, slow_q, trip, pulse_on, alert_q} :
                     32'h00000000;

    // write address and data capture, either order
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            aw_hold_q <= 1'b0;
            w_hold_q <= 1'b0;
            awaddr_q <= 8'h00;
            wdata_q <= 32'h00000000;
            wstrb_q <= 4'h0;
        end
        else if (ce_i)
        begin
            if (aw_take)
            begin
                aw_hold_q <= 1'b1;
                awaddr_q <= s_axi_awaddr;
            end
            else if (do_write)
                aw_hold_q <= 1'b0;
            if (w_take)
            begin
                w_hold_q <= 1'b1;
                wdata_q <= s_axi_wdata;
                wstrb_q <= s_axi_wstrb;
            end
            else if (do_write)
                w_hold_q <= 1'b0;
        end
    end

    // register update and write response
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            mask_q <= MASK_RST;
            full_q <= FULL_RST;
            ctrl_q <= CTRL_RST;
            bvalid_q <= 1'b0;
            bresp_q <= RESP_OKAY;
        end
        else if (ce_i)
        begin
            if (do_write)
            begin
                if (awaddr_q == MASK_ADDR)
                    mask_q <= mask_merge[MASK_W-1:0] & MASK_WMASK; // R8
                if (awaddr_q == FULL_ADDR)
                    full_q <= full_merge[15:0] & FULL_WMASK;
                if (awaddr_q == CTRL_ADDR)
                    ctrl_q <= ctrl_merge[0:0];
                bvalid_q <= 1'b1;
                bresp_q <= wr_hit ? RESP_OKAY : RESP_SLVERR;
            end
            else if (s_axi_bready)
                bvalid_q <= 1'b0;
        end
    end

    // read response, one cycle after the address is taken
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            rvalid_q <= 1'b0;
            rdata_q <= 32'h00000000;
            rresp_q <= RESP_OKAY;
            rd_mask_q <= 1'b0;
        end
        else if (ce_i)
        begin
            if (ar_take)
            begin
                rvalid_q <= 1'b1;
                rdata_q <= rd_word;
                rresp_q <= rd_hit ? RESP_OKAY : RESP_SLVERR;
                rd_mask_q <= s_axi_araddr == MASK_ADDR;
            end
            else if (s_axi_rready)
                rvalid_q <= 1'b0;
        end
    end

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    sequence pulse_start_s;
        ce_i && pulse_en && conv_done_i;
    endsequence
    sequence pulse_last_s;
        ce_i && pulse_en && !conv_done_i && pulse_cnt_q == PULSE_CNT_W'(1);
    endsequence

    uv_route_a: assert property (ce_i && uv_en[3] && uv_alert_i[3] |=> alert_q) // R1
        else $error("enabled undervoltage did not reach pin");
    uv_block_a: assert property (ce_i && mask_q[11:4] == 8'h80 && mask_q[3:1] == 3'h0 && !pulse_on
                                 && !uv_alert_i[0] |=> !alert_q) // R1
        else $error("blocked undervoltage reached pin");
    op_route_a: assert property (ce_i && mask_q[OP_CH1_BIT] && op_alert_i[0] |=> alert_q) // R2
        else $error("enabled overpower did not reach pin");
    acc_route_a: assert property (ce_i && mask_q[ACC_BIT] && trip[2] |=> alert_q) // R3
        else $error("accumulator trip not routed");
    cnt_route_a: assert property (ce_i && mask_q[CNT_BIT] && trip[4] |=> alert_q) // R4
        else $error("counter trip not routed");
    pulse_load_a: assert property (pulse_start_s |=> pulse_cnt_q == PULSE_CNT_W'(PULSE_CYC) ##1 alert_q) // R5
        else $error("conversion pulse did not start");
    pulse_end_a: assert property (pulse_last_s |=> !pulse_on) // R5
        else $error("conversion pulse length wrong");
    pulse_off_a: assert property (ce_i && !pulse_en |=> !pulse_on) // R5
        else $error("pulse while disabled");
    slow_block_a: assert property (ce_i && alert_mode |=> !slow_request_o) // R7
        else $error("slow input active in alert function");
    pin_drive_a: assert property (ce_i && alert_mode && alert_d |=> !second_alert_pin_oe_n_o && alert_q) // R11
        else $error("pin not driven for alert");
    pin_idle_a: assert property (ce_i && !alert_mode |=> second_alert_pin_oe_n_o) // R6
        else $error("pin driven outside alert function");
    bit0_zero_a: assert property (rvalid_q && rd_mask_q |-> !s_axi_rdata[0]) // R8
        else $error("mask bit 0 read nonzero");
endmodule // aps_alert2_route

/* File: logic/aps_fill_chk.sv */
// one fullness comparator: level against the coded trip fraction
// assumes level is the accumulator or sample counter fill scaled to FILL_W bits
`timescale 1ns/1ps
module aps_fill_chk import aps_pkg::*; #(
    parameter int FILL_W = 16
) (
    // clock, reset, enable
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    // comparison bundle
    aps_fill_if.chk fill
);
    localparam logic [FILL_W-1:0] LVL_MAX = {FILL_W{1'b1}};
    localparam logic [FILL_W-1:0] LVL_15_16 = {4'hf, {(FILL_W-4){1'b0}}};
    localparam logic [FILL_W-1:0] LVL_7_8 = {3'h7, {(FILL_W-3){1'b0}}};
    localparam logic [FILL_W-1:0] LVL_3_4 = {2'h3, {(FILL_W-2){1'b0}}};

    logic trip_q;
    wire logic [FILL_W-1:0] thr;
    wire logic hit;

    // coded fraction to threshold; overflow always trips
    assign thr = (fill.code == FILL_FULL) ? LVL_MAX :
                 (fill.code == FILL_15_16) ? LVL_15_16 :
                 (fill.code == FILL_7_8) ? LVL_7_8 : LVL_3_4; // R10
    assign hit = fill.ovf | (fill.level >= thr);
    assign fill.trip = trip_q;

    // registered so the pin never sees comparator glitches
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            trip_q <= 1'b0;
        else if (ce_i)
            trip_q <= hit;
    end

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    full_code_a: assert property (ce_i && fill.code == FILL_FULL && !fill.ovf && fill.level != LVL_MAX |=> !fill.trip) // R10
        else $error("full code tripped below full");
    quarter_code_a: assert property (ce_i && fill.code == FILL_3_4 && fill.level[FILL_W-1 -: 2] == 2'h3 |=> fill.trip) // R10
        else $error("three-quarter code missed trip");
    eighth_code_a: assert property (ce_i && fill.code == FILL_7_8 && !fill.ovf && fill.level < LVL_7_8 |=> !fill.trip) // R10
        else $error("seven-eighth code tripped early");
    ovf_trip_a: assert property (ce_i && fill.ovf |=> fill.trip) // R10
        else $error("overflow did not trip");
endmodule // aps_fill_chk

/* File: logic/aps_fill_if.sv */
// fullness check bundle between the router and one comparator
// assumes both ends share the router clock
`timescale 1ns/1ps
interface aps_fill_if #(parameter int FILL_W = 16) ();
    logic [FILL_W-1:0] level;
    logic ovf;
    logic [1:0] code;
    logic trip;
    modport chk (input level, input ovf, input code, output trip);
    modport src (output level, output ovf, output code, input trip);
endinterface

/* File: logic/aps_pkg.sv */
// constants shared by the second alert pin routing block
// assumes a 250 MHz clock and a 32-bit AXI4-Lite register bus
// Function
// R1: four undervoltage enables, ch1..ch4 at bits 11..8, route that alert to pin.
// R2: four overpower enables, ch1..ch4 at bits 7..4, route that alert to pin.
// R3: bit 3 routes any accumulator overflow or fullness trip to the pin.
// R4: bit 2 routes sample counter overflow or fullness trip to the pin.
// R5: bit 1 gives a 5 us pin pulse at each conversion end.
// R6: host must put the pin in alert function before expecting pulses.
// R7: slow-sampling input is unavailable while the pin is an alert output.
// R8: mask bit 0 is unimplemented, reads zero, ignores writes.
// R9: host enables alerts globally first, disables them while changing thresholds.
// R10: fullness codes: 00 full, 01 15/16 (default), 10 7/8, 11 3/4.
// R11: pin is the OR of all enabled sources plus the enabled pulse.
package aps_pkg;
    // register indices and byte addresses
    localparam logic [7:0] CTRL_IDX = 8'h00;
    localparam logic [7:0] STAT_IDX = 8'h01;
    localparam logic [7:0] MASK_IDX = 8'h28;
    localparam logic [7:0] FULL_IDX = 8'h29;
    localparam logic [7:0] CTRL_ADDR = {CTRL_IDX[5:0], 2'b00};
    localparam logic [7:0] STAT_ADDR = {STAT_IDX[5:0], 2'b00};
    localparam logic [7:0] MASK_ADDR = {MASK_IDX[5:0], 2'b00};
    localparam logic [7:0] FULL_ADDR = {FULL_IDX[5:0], 2'b00};
    // routing mask layout
    localparam int MASK_W = 24;
    localparam logic [23:0] MASK_RST = 24'h000000;
    localparam logic [23:0] MASK_WMASK = 24'hfffffe;
    localparam int UV_CH1_BIT = 11;
    localparam int OP_CH1_BIT = 7;
    localparam int ACC_BIT = 3;
    localparam int CNT_BIT = 2;
    localparam int PULSE_BIT = 1;
    // fullness limit layout
    localparam logic [15:0] FULL_RST = 16'h5540;
    localparam logic [15:0] FULL_WMASK = 16'hffc0;
    localparam int FULL_CH1_LSB = 14;
    localparam logic [1:0] FILL_FULL = 2'h0;
    localparam logic [1:0] FILL_15_16 = 2'h1;
    localparam logic [1:0] FILL_7_8 = 2'h2;
    localparam logic [1:0] FILL_3_4 = 2'h3;
    // control register
    localparam int ALERT_MODE_BIT = 0;
    localparam logic [0:0] CTRL_RST = 1'h0;
    // conversion-end pulse timing
    localparam int CLK_PERIOD_PS = 4000;
    localparam int PULSE_PS = 5000000;
    localparam int PULSE_CYC = (PULSE_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int PULSE_CNT_W = 11;
    // bus responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

/* File: sim/aps_alert2_route_test.sv */
// self-checking bench for the second alert pin routing block
// assumes the host model on the pin and a 250 MHz clock
`timescale 1ns/1ps
module aps_alert2_route_test;
    import aps_pkg::*;
    logic clk_i, rst_i, ce_i, awvalid, wvalid, bready, arvalid, rready;
    logic awready, wready, bvalid, arready, rvalid, covf, cdone, drv_low, pin_lvl, pin_o, oe_n, slow;
    logic [7:0] awaddr, araddr;
    logic [31:0] wdata, rdata, m, s, seed = 32'hf79d401e;
    logic [3:0] uv, op, aovf;
    logic [63:0] afill, fv;
    logic [15:0] cfill;
    logic [1:0] bresp, rresp, rsp;
    int low_len, falls, fails = 0, checks_done = 0, cyc = 0, n;
    aps_alert2_route #(.FILL_W(16)) dut (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .uv_alert_i(uv), .op_alert_i(op), .accum_fill_i(afill), .accum_ovf_i(aovf),
        .count_fill_i(cfill), .count_ovf_i(covf), .conv_done_i(cdone), .second_alert_pin_i(pin_lvl),
        .second_alert_pin_o(pin_o), .second_alert_pin_oe_n_o(oe_n), .slow_request_o(slow));
    aps_host_model host (.clk_i(clk_i), .oe_n_i(oe_n), .pin_o_i(pin_o), .drive_low_i(drv_low),
        .pin_lvl_o(pin_lvl), .low_len_o(low_len), .falls_o(falls));
    // xorshift so a rerun repeats the same stimulus
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    // pin is asserted when any routed source is up
    function automatic logic routed(input logic [31:0] mk, input logic [31:0] src);
        return |(mk[11:2] & src[11:2]);
    endfunction
    // trip level of a fullness code, top bits of a 16-bit fill
    function automatic logic [15:0] thr(input logic [1:0] c);
        return (c == 2'h0) ? 16'hffff : (c == 2'h1) ? 16'hf000 : (c == 2'h2) ? 16'he000 : 16'hc000;
    endfunction
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        checks_done++;
        if (g !== e)
        begin
            fails++;
            $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task automatic close_out();
        $display("checks_done %0d fails %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    // readies are looked at mid-cycle, where they equal their value at the next edge
    task automatic wrc(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e);
        logic aw_d, w_d, aw_h, w_h;
        aw_d = 1'b0;
        w_d = 1'b0;
        @(posedge clk_i);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (!(aw_d && w_d))
        begin
            @(negedge clk_i);
            aw_h = awready && !aw_d;
            w_h = wready && !w_d;
            @(posedge clk_i);
            if (aw_h)
                awvalid <= 1'b0;
            if (w_h)
                wvalid <= 1'b0;
            aw_d = aw_d | aw_h;
            w_d = w_d | w_h;
        end
        do @(negedge clk_i); while (bvalid !== 1'b1);
        rsp = bresp;
        @(posedge clk_i);
        bready <= 1'b0;
        chk({30'h0, rsp}, {30'h0, e});
    endtask
    task automatic rdc(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] e);
        @(posedge clk_i);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do @(negedge clk_i); while (arready !== 1'b1);
        @(posedge clk_i);
        arvalid <= 1'b0;
        do @(negedge clk_i); while (rvalid !== 1'b1);
        chk(rdata, ed);
        chk({30'h0, rresp}, {30'h0, e});
        @(posedge clk_i);
        rready <= 1'b0;
    endtask
    task automatic set_src(input logic [31:0] sv, input logic [1:0] ch);
        @(posedge clk_i);
        uv <= {sv[8], sv[9], sv[10], sv[11]};
        op <= {sv[4], sv[5], sv[6], sv[7]};
        aovf <= sv[3] ? 4'h1 << ch : 4'h0;
        covf <= sv[2];
    endtask
    // fullness sources need two edges, so four is ample
    task automatic pin_chk(input logic e);
        repeat (4) @(posedge clk_i);
        @(negedge clk_i);
        chk({31'h0, oe_n}, {31'h0, !e});
    endtask
    task automatic conv_pulse();
        @(posedge clk_i);
        cdone <= 1'b1;
        @(posedge clk_i);
        cdone <= 1'b0;
        repeat (PULSE_CYC + 40) @(posedge clk_i);
        @(negedge clk_i);
    endtask
    initial
    begin
        clk_i = 1'b0;
        forever #2 clk_i = ~clk_i;
    end
    // hang guard, far above the few thousand cycles the run needs
    always @(posedge clk_i)
    begin
        cyc <= cyc + 1;
        if (cyc == 40000)
        begin
            fails++;
            close_out();
        end
    end
    initial
    begin
        {rst_i, ce_i} = 2'b11;
        {awvalid, wvalid, bready, arvalid, rready, covf, cdone, drv_low} = 8'h0;
        {awaddr, araddr, wdata, uv, op, aovf, afill, cfill} = '0;
        repeat (12) @(posedge clk_i);
        rst_i <= 1'b0;
        rdc(MASK_ADDR, 32'h0, RESP_OKAY);
        rdc(FULL_ADDR, {16'h0, FULL_RST}, RESP_OKAY);
        rdc(CTRL_ADDR, 32'h0, RESP_OKAY);
        wrc(8'h10, 32'hffffffff, RESP_SLVERR);
        rdc(8'h10, 32'h0, RESP_SLVERR);
        // alert function before any routing is expected to show
        wrc(CTRL_ADDR, 32'h1, RESP_OKAY);
        // each source alone, then every other bit without its own
        for (int b = 2; b < 12; b++)
        begin
            wrc(MASK_ADDR, 32'h1 << b, RESP_OKAY);
            set_src(32'h1 << b, b[1:0]);
            pin_chk(1'b1);
            rdc(STAT_ADDR, (b == 2) ? 32'h41 : (b == 3) ? 32'h21 : 32'h1, RESP_OKAY);
            wrc(MASK_ADDR, 32'hffc & ~(32'h1 << b), RESP_OKAY);
            pin_chk(1'b0);
        end
        for (int i = 0; i < 24; i++)
        begin
            m = rnd();
            s = rnd();
            wrc(MASK_ADDR, m, RESP_OKAY);
            rdc(MASK_ADDR, m & 32'h00fffffe, RESP_OKAY);
            set_src(s, m[13:12]);
            pin_chk(routed(m, s));
        end
        set_src(32'h0, 2'h0);
        // clock enable low freezes the pin and refuses the bus
        wrc(MASK_ADDR, 32'h800, RESP_OKAY);
        @(posedge clk_i);
        ce_i <= 1'b0;
        uv <= 4'h1;
        pin_chk(1'b0);
        chk({31'h0, awready}, 32'h0);
        @(posedge clk_i);
        ce_i <= 1'b1;
        pin_chk(1'b1);
        set_src(32'h0, 2'h0);
        // fill one below and exactly at each trip level
        for (int c = 0; c < 4; c++)
        begin
            wrc(FULL_ADDR, {16'h0, {5{c[1:0]}}, 6'h0}, RESP_OKAY);
            rdc(FULL_ADDR, {16'h0, {5{c[1:0]}}, 6'h0}, RESP_OKAY);
            for (int k = 0; k < 2; k++)
            begin
                m = rnd();
                fv = 64'h0;
                fv[16 * m[1:0] +: 16] = thr(c[1:0]) - 16'h1 + k[15:0];
                @(posedge clk_i);
                afill <= fv;
                cfill <= thr(c[1:0]) - 16'h1 + k[15:0];
                wrc(MASK_ADDR, 32'h8, RESP_OKAY);
                pin_chk(k == 1);
                wrc(MASK_ADDR, 32'h4, RESP_OKAY);
                pin_chk(k == 1);
            end
        end
        @(posedge clk_i);
        afill <= 64'h0;
        cfill <= 16'h0;
        wrc(MASK_ADDR, 32'h2, RESP_OKAY);
        n = falls;
        conv_pulse();
        chk(32'(low_len), PULSE_CYC);
        chk(32'(falls), 32'(n + 1));
        wrc(MASK_ADDR, 32'h0, RESP_OKAY);
        conv_pulse();
        chk(32'(falls), 32'(n + 1));
        // pulse enabled but the pin left as an input
        wrc(CTRL_ADDR, 32'h0, RESP_OKAY);
        wrc(MASK_ADDR, 32'h2, RESP_OKAY);
        conv_pulse();
        chk(32'(falls), 32'(n + 1));
        // slow input follows the line only while the pin is not an alert output
        drv_low <= 1'b1;
        pin_chk(1'b0);
        chk({31'h0, slow}, 32'h0);
        drv_low <= 1'b0;
        pin_chk(1'b0);
        chk({31'h0, slow}, 32'h1);
        wrc(CTRL_ADDR, 32'h1, RESP_OKAY);
        pin_chk(1'b0);
        chk({31'h0, slow}, 32'h0);
        close_out();
    end
endmodule // aps_alert2_route_test

/* File: sim/aps_host_model.sv */
// host-side model of the second alert pin: pull-up, wired-and and pulse timing
// assumes the block drives the pin open drain, enable active low
`timescale 1ns/1ps
module aps_host_model (
    // clock
    input wire logic clk_i,
    // pin as driven by the block
    input wire logic oe_n_i,
    input wire logic pin_o_i,
    // host side of the line
    input wire logic drive_low_i,
    output logic pin_lvl_o,
    output int low_len_o,
    output int falls_o
);
    int run_q = 0;
    int len_q = 0;
    int fall_q = 0;
    logic lvl_q = 1'b1;
    // one process owns each count; the ports only mirror them
    assign low_len_o = len_q;
    assign falls_o = fall_q;
    // pull-up unless a party sinks the line; the host sinks it whenever drive_low_i is high
    assign pin_lvl_o = ((oe_n_i === 1'b0) ? pin_o_i : 1'b1) & !drive_low_i;
    // measure each low stretch, latched once the line is high again
    always @(posedge clk_i)
    begin
        if (!pin_lvl_o)
            run_q <= run_q + 1;
        else if (!lvl_q)
        begin
            len_q <= run_q;
            run_q <= 0;
        end
        if (lvl_q && !pin_lvl_o)
            fall_q <= fall_q + 1;
        lvl_q <= pin_lvl_o;
    end
endmodule // aps_host_model
